/* switch_config_params.svh */
// register offsets, field positions, reset values and timing counts of the config block
`ifndef SWITCH_CONFIG_PARAMS_SVH
`define SWITCH_CONFIG_PARAMS_SVH
`define OFS_CMD_ONE 5'h08
`define OFS_CMD_TWO 5'h0A
`define OFS_MSG 5'h0C
`define OFS_ISTA 5'h0E
`define OFS_ESTA_A 5'h10
`define OFS_ESTA_B 5'h11
`define OFS_IMASK 5'h12
`define OFS_EMASK_A 5'h14
`define OFS_EMASK_B 5'h15
`define OFS_GPIN 5'h16
`define OFS_GIN_ONE 5'h04
`define OFS_GIN_TWO 5'h05
`define OFS_SPA 5'h00
`define OFS_DPA 5'h02
`define OFS_TSV 5'h1E
`define RST_IMASK 8'h3D
`define RST_EMASK_A 8'h3F
`define RST_EMASK_B 8'hFF
`define RST_RANGE 4'h1
`define BIT_RDY 0
`define BIT_NFC 1
`define BIT_TSA 2
`define BIT_GPIO 3
`define BIT_ER1 4
`define BIT_ER2 5
`define BIT_STR 6
`define BIT_ANALOG_PLL_LOCK 7
`define BIT_PLLFAIL 6
`define CLK_MHZ 10
`define GAP_SHORT_NS 20
`define GAP_LONG_NS 300
`define GAP_SHORT_CYC (((`GAP_SHORT_NS * `CLK_MHZ) + 999) / 1000)
`define GAP_LONG_CYC (((`GAP_LONG_NS * `CLK_MHZ) + 999) / 1000)
`endif

/* switch_config_pkg.sv */
// types shared by the config command block
`default_nettype none
package switch_config_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_EXTFREQ = 4'h1, OP_PARALLEL = 4'h2, OP_IRQPIN = 4'h3,
    OP_STANDBY = 4'h4, OP_LOOP = 4'h5, OP_FRAME = 4'h6, OP_CLOCK = 4'h7,
    OP_RANGE = 4'h8, OP_RDCFG = 4'h9, OP_RDCLK = 4'hA, OP_RDLINE = 4'hB,
    OP_RDHBUS = 4'hC, OP_RDSHIFT = 4'hD, OP_RSVD = 4'hE, OP_SWRESET = 4'hF
  } cmd_two_e;
  typedef enum logic [3:0] {
    OP1_STREAM = 4'hE, OP1_SHIFT = 4'hF
  } cmd_one_e;
endpackage
`default_nettype wire

/* switch_config_command_and_irq_regs.sv */
// configuration command decoder, status and mask registers of the switching device
`timescale 1ns/1ps
`default_nettype none
`include "switch_config_params.svh"
// Summary of operation
// RL1 - host keeps stream source and destination distinct
// RL2 - stream command: mode, establish/release, release all
// RL3 - bit shift from general input one, target select
// RL4 - command two: code low, info high; 0000 idles
// RL5 - external frequency first; bit0 picks 32/16 MHz
// RL6 - fallback failure sets pll and source flags
// RL7 - valid clock clears flags; host toggles fallback
// RL8 - improved pll start issued once after power-up
// RL9 - parallel mode uses first eight lines
// RL10 - interrupt pin polarity, open drain, gap length
// RL11 - standby enables pcm and bus outputs
// RL12 - pcm loop and bus loop enables
// RL13 - aux clock line as framed signal
// RL14 - aux clock line as clock signal
// RL15 - one-hot data rate range ored together
// RL16 - host sets data rate range once
// RL17 - read configuration picks one of sixteen
// RL18 - read clock line, line rate, shift settings
// RL19 - software reset held while bit0 set
// RL20 - main status ready, full, arrived, stream, lock
// RL21 - change flags for error registers and inputs
// RL22 - mask bit zero lets flag raise interrupt
// RL23 - read results land in time-slot value register
// RL24 - reserved code changes nothing
// RL25 - host waits for ready before next command
module switch_config_command_and_irq_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [7:0] regRdData,
  input wire logic commandReady,
  input wire logic connectionsFull,
  input wire logic timeslotArrived,
  input wire logic analogPllLock,
  input wire logic [5:0] clockFailA,
  input wire logic [7:0] clockFailB,
  input wire logic [7:0] portInputs,
  input wire logic wideInterface,
  output logic interruptRequestOut,
  output logic interruptRequestOe,
  output logic extFreqHalf,
  output logic fallbackEnable,
  output logic pllImproved,
  output logic parallelMode,
  output logic pcmEnable,
  output logic busEnable,
  output logic pcmClockSlave,
  output logic pcmLoop,
  output logic busLoop,
  output logic [3:0] rateRange,
  output logic [7:0] auxClockEnable,
  output logic [7:0] auxClockFrame,
  output logic [7:0] auxClockInvert,
  output logic streamActive,
  output logic [1:0] streamMode,
  output logic [3:0] shiftTarget,
  output logic [7:0] shiftValue,
  output logic softReset
);

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wrCmdTwo;
  logic wrCmdOne;
  logic [3:0] code;
  logic [3:0] info;
  assign wrCmdTwo = regWrStrobe && hit(regAddr, `OFS_CMD_TWO);
  assign wrCmdOne = regWrStrobe && hit(regAddr, `OFS_CMD_ONE);
  assign code = regWrData[3:0]; // RL4
  assign info = regWrData[7:4]; // RL4

  logic [7:0] cmdTwo_q, cmdOne_q, msg_q, imask_q, emaskA_q, emaskB_q;
  logic [7:0] ginOne_q, ginTwo_q, spa_q, dpa_q;
  // plain storage registers written by the host
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmdTwo_q <= 8'h00;
      cmdOne_q <= 8'h00;
      msg_q <= 8'h00;
      imask_q <= `RST_IMASK; // RL22
      emaskA_q <= `RST_EMASK_A; // RL22
      emaskB_q <= `RST_EMASK_B; // RL22
      ginOne_q <= 8'h00;
      ginTwo_q <= 8'h00;
      spa_q <= 8'h00;
      dpa_q <= 8'h00;
    end
    else if (regWrStrobe)
    begin
      case (regAddr)
        `OFS_CMD_TWO: cmdTwo_q <= regWrData;
        `OFS_CMD_ONE: cmdOne_q <= regWrData;
        `OFS_MSG: msg_q <= regWrData;
        `OFS_IMASK: imask_q <= regWrData & 8'h3D;
        `OFS_EMASK_A: emaskA_q <= regWrData & 8'h3F;
        `OFS_EMASK_B: emaskB_q <= regWrData;
        `OFS_GIN_ONE: ginOne_q <= regWrData;
        `OFS_GIN_TWO: ginTwo_q <= regWrData;
        `OFS_SPA: spa_q <= regWrData;
        `OFS_DPA: dpa_q <= regWrData;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command register one tail: stream switch and bit shift
  logic [7:0] shiftIn_q;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      streamActive <= 1'b0;
      streamMode <= 2'h0;
      shiftTarget <= 4'h0;
      shiftValue <= 8'h00;
      shiftIn_q <= 8'h00;
    end
    else if (wrCmdOne && code == switch_config_pkg::OP1_STREAM)
    begin
      // source and destination equality is the host's burden, not checked
      if (info[3])
        streamActive <= 1'b0; // RL2
      else
      begin
        streamMode <= info[1:0]; // RL2
        streamActive <= info[2]; // RL2
      end
    end
    else if (wrCmdOne && code == switch_config_pkg::OP1_SHIFT)
    begin
      shiftValue <= ginOne_q; // RL3
      shiftTarget <= 4'h1 << info[1:0]; // RL3
      if (info[1:0] != 2'h2)
        shiftIn_q <= ginOne_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command register two: configuration state
  logic [2:0] irqCfg_q;
  logic [3:0] standby_q;
  logic [7:0] auxSel;
  assign auxSel = 8'h01 << info[2:0];
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      extFreqHalf <= 1'b0;
      fallbackEnable <= 1'b0;
      pllImproved <= 1'b0;
      parallelMode <= 1'b0;
      irqCfg_q <= 3'h0;
      standby_q <= 4'h0;
      pcmLoop <= 1'b0;
      busLoop <= 1'b0;
      rateRange <= `RST_RANGE;
      auxClockEnable <= 8'h00;
      auxClockFrame <= 8'h00;
      auxClockInvert <= 8'h00;
      softReset <= 1'b0;
    end
    else if (wrCmdTwo)
    begin
      case (code)
        switch_config_pkg::OP_EXTFREQ:
        begin
          extFreqHalf <= info[0]; // RL5
          fallbackEnable <= info[1]; // RL7
          if (info[2])
            pllImproved <= 1'b1; // RL8
        end
        switch_config_pkg::OP_PARALLEL: parallelMode <= info[0]; // RL9
        switch_config_pkg::OP_IRQPIN: irqCfg_q <= info[2:0]; // RL10
        switch_config_pkg::OP_STANDBY: standby_q <= info; // RL11
        switch_config_pkg::OP_LOOP:
        begin
          pcmLoop <= info[0]; // RL12
          busLoop <= info[1]; // RL12
        end
        switch_config_pkg::OP_FRAME:
        begin
          auxClockEnable <= auxClockEnable | auxSel; // RL13
          auxClockFrame <= auxClockFrame | auxSel; // RL13
          auxClockInvert <= info[3] ? (auxClockInvert | auxSel) : (auxClockInvert & ~auxSel);
        end
        switch_config_pkg::OP_CLOCK:
        begin
          auxClockEnable <= auxClockEnable | auxSel; // RL14
          auxClockFrame <= auxClockFrame & ~auxSel; // RL14
        end
        switch_config_pkg::OP_RANGE: rateRange <= info; // RL15
        switch_config_pkg::OP_SWRESET: softReset <= info[0]; // RL19
        default: ; // RL24
      endcase
    end
  end

  // standby outputs follow the stored standby field
  assign pcmEnable = standby_q[0]; // RL11
  assign busEnable = standby_q[1]; // RL11
  assign pcmClockSlave = standby_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // read commands load the time-slot value register
  logic [7:0] tsv_q;
  logic tsvNew;
  function automatic logic [7:0] cfgSel(input logic [3:0] s);
    case (s)
      4'hA: cfgSel = {7'h00, extFreqHalf};
      4'hB: cfgSel = {7'h00, parallelMode};
      4'hC: cfgSel = {5'h00, irqCfg_q};
      4'hD: cfgSel = {6'h00, standby_q[1:0]};
      4'hE: cfgSel = {6'h00, busLoop, pcmLoop};
      4'hF: cfgSel = {4'h0, rateRange};
      4'h9: cfgSel = {6'h00, fallbackEnable, 1'b0};
      default: cfgSel = 8'h00;
    endcase
  endfunction
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tsv_q <= 8'h00;
      tsvNew <= 1'b0;
    end
    else
    begin
      tsvNew <= 1'b0;
      if (wrCmdTwo)
      begin
        tsvNew <= 1'b1;
        case (code)
          switch_config_pkg::OP_RDCFG: tsv_q <= cfgSel(info); // RL17
          switch_config_pkg::OP_RDCLK:
            tsv_q <= {7'h00, auxClockFrame[info[2:0]]}; // RL18
          switch_config_pkg::OP_RDLINE: tsv_q <= {4'h0, rateRange}; // RL18
          switch_config_pkg::OP_RDHBUS: tsv_q <= {4'h0, rateRange}; // RL18
          switch_config_pkg::OP_RDSHIFT:
            tsv_q <= info[0] ? shiftValue : shiftIn_q; // RL23
          default: tsvNew <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error status: live failures, pll flag joins any failure under fallback
  logic [7:0] estaA_q, estaB_q, gpin_q;
  logic [7:0] estaBNext;
  logic anyFail;
  assign anyFail = (|clockFailA) || (|clockFailB);
  always_comb
  begin
    estaBNext = clockFailB;
    if (fallbackEnable && anyFail)
      estaBNext[`BIT_PLLFAIL] = 1'b1; // RL6
  end
  logic [7:0] ista_q;
  logic [7:0] istaEvents;
  always_comb
  begin
    istaEvents = 8'h00;
    istaEvents[`BIT_ER1] = (estaA_q != {2'b00, clockFailA}); // RL21
    istaEvents[`BIT_ER2] = wideInterface ? 1'b0 : (estaB_q != estaBNext); // RL21
    istaEvents[`BIT_GPIO] = (gpin_q != portInputs); // RL21
  end
  logic rdIsta;
  assign rdIsta = regRdStrobe && hit(regAddr, `OFS_ISTA);
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      estaA_q <= 8'h00;
      estaB_q <= 8'h00;
      gpin_q <= 8'h00;
      ista_q <= 8'h00;
    end
    else
    begin
      // flags follow the clocks both ways, so recovery clears them
      estaA_q <= {2'b00, clockFailA}; // RL6 RL7
      estaB_q <= estaBNext; // RL7
      gpin_q <= portInputs;
      // change flags clear on read; a new event in that cycle wins
      ista_q[`BIT_ER1] <= istaEvents[`BIT_ER1] | (ista_q[`BIT_ER1] & ~rdIsta);
      ista_q[`BIT_ER2] <= istaEvents[`BIT_ER2] | (ista_q[`BIT_ER2] & ~rdIsta);
      ista_q[`BIT_GPIO] <= istaEvents[`BIT_GPIO] | (ista_q[`BIT_GPIO] & ~rdIsta);
      ista_q[`BIT_TSA] <= tsvNew | timeslotArrived
        | (ista_q[`BIT_TSA] & ~(regRdStrobe && hit(regAddr, `OFS_TSV))); // RL20
      ista_q[`BIT_RDY] <= commandReady; // RL20
      ista_q[`BIT_NFC] <= connectionsFull; // RL20
      ista_q[`BIT_STR] <= streamActive; // RL20
      ista_q[`BIT_ANALOG_PLL_LOCK] <= analogPllLock; // RL20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin with minimum inactive gap
  localparam logic [5:0] GAP_SHORT = 6'(`GAP_SHORT_CYC);
  localparam logic [5:0] GAP_LONG = 6'(`GAP_LONG_CYC);
  logic pending;
  logic irqActive_q;
  logic [5:0] gap_q;
  assign pending = |(ista_q & ~imask_q) || |(estaA_q & ~emaskA_q)
    || |(estaB_q & ~emaskB_q); // RL22
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irqActive_q <= 1'b0;
      gap_q <= 6'h00;
    end
    else if (irqActive_q && !pending)
    begin
      irqActive_q <= 1'b0;
      gap_q <= irqCfg_q[2] ? GAP_LONG : GAP_SHORT; // RL10
    end
    else if (gap_q != 6'h00)
      gap_q <= gap_q - 6'h01;
    else if (pending)
      irqActive_q <= 1'b1;
  end
  // polarity and drive style; open drain pulls low only when active
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      interruptRequestOut <= 1'b1;
      interruptRequestOe <= 1'b0;
    end
    else
    begin
      case (irqCfg_q[1:0])
        2'h1:
        begin
          interruptRequestOut <= irqActive_q; // RL10
          interruptRequestOe <= 1'b1;
        end
        2'h2:
        begin
          interruptRequestOut <= 1'b0; // RL10
          interruptRequestOe <= irqActive_q;
        end
        default:
        begin
          interruptRequestOut <= ~irqActive_q; // RL10
          interruptRequestOe <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      regRdData <= 8'h00;
    else if (regRdStrobe)
    begin
      case (regAddr)
        `OFS_CMD_TWO: regRdData <= cmdTwo_q;
        `OFS_CMD_ONE: regRdData <= cmdOne_q;
        `OFS_MSG: regRdData <= msg_q;
        `OFS_ISTA: regRdData <= ista_q;
        `OFS_ESTA_A: regRdData <= estaA_q;
        `OFS_ESTA_B: regRdData <= estaB_q;
        `OFS_IMASK: regRdData <= imask_q;
        `OFS_EMASK_A: regRdData <= emaskA_q;
        `OFS_EMASK_B: regRdData <= emaskB_q;
        `OFS_GPIN: regRdData <= gpin_q;
        `OFS_GIN_ONE: regRdData <= ginOne_q;
        `OFS_GIN_TWO: regRdData <= ginTwo_q;
        `OFS_SPA: regRdData <= spa_q;
        `OFS_DPA: regRdData <= dpa_q;
        `OFS_TSV: regRdData <= tsv_q; // RL23
        default: regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

endmodule
`default_nettype wire

/* switch_config_checker.sv */
// assertion checker for the config command block ports
`timescale 1ns/1ps
`default_nettype none
`include "switch_config_params.svh"
module switch_config_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [7:0] regRdData,
  input wire logic analogPllLock,
  input wire logic extFreqHalf,
  input wire logic fallbackEnable,
  input wire logic parallelMode,
  input wire logic pcmEnable,
  input wire logic busEnable,
  input wire logic pcmLoop,
  input wire logic busLoop,
  input wire logic [3:0] rateRange,
  input wire logic [7:0] auxClockEnable,
  input wire logic softReset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // command write decode; each level must follow one cycle after the write
  logic cmdWr;
  logic [3:0] code;
  assign cmdWr = regWrStrobe && regAddr == `OFS_CMD_TWO;
  assign code = regWrData[3:0];
  property p_extFreq;
    cmdWr && code == 4'h1 |=> {fallbackEnable, extFreqHalf} == $past(regWrData[5:4]);
  endproperty
  a_extFreq: assert property (p_extFreq) else $error("frequency setting wrong");
  property p_parallel;
    cmdWr && code == 4'h2 |=> parallelMode == $past(regWrData[4]);
  endproperty
  a_parallel: assert property (p_parallel) else $error("parallel mode wrong");
  property p_standby;
    cmdWr && code == 4'h4 |=> {busEnable, pcmEnable} == $past(regWrData[5:4]);
  endproperty
  a_standby: assert property (p_standby) else $error("standby enables wrong");
  property p_loop;
    cmdWr && code == 4'h5 |=> {busLoop, pcmLoop} == $past(regWrData[5:4]);
  endproperty
  a_loop: assert property (p_loop) else $error("loop enables wrong");
  property p_range;
    cmdWr && code == 4'h8 |=> rateRange == $past(regWrData[7:4]);
  endproperty
  a_range: assert property (p_range) else $error("rate range wrong");
  property p_auxClock;
    cmdWr && code == 4'h7 |=> auxClockEnable[$past(regWrData[6:4])];
  endproperty
  a_auxClock: assert property (p_auxClock) else $error("aux clock line not driven");
  property p_softReset;
    cmdWr && code == 4'hF |=> softReset == $past(regWrData[4]);
  endproperty
  a_softReset: assert property (p_softReset) else $error("soft reset wrong");
  // no-operation must leave rateRange and pcmEnable alone, the reserved code auxClockEnable and parallelMode
  property p_idle;
    cmdWr && code == 4'h0 |=> $stable(rateRange) && $stable(pcmEnable);
  endproperty
  a_idle: assert property (p_idle) else $error("no-operation changed a level");
  property p_reserved;
    cmdWr && code == 4'hE |=> $stable(auxClockEnable) && $stable(parallelMode);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");
  // the lock bit is compared against a held input so sync delay cannot matter
  property p_lockRead;
    regRdStrobe && regAddr == `OFS_ISTA && $stable(analogPllLock)
      |=> regRdData[7] == $past(analogPllLock);
  endproperty
  a_lockRead: assert property (p_lockRead) else $error("lock bit wrong");
endmodule
bind switch_config_command_and_irq_regs switch_config_checker checker_i (
  .core_clk, .sys_rst, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
  .analogPllLock, .extFreqHalf, .fallbackEnable, .parallelMode, .pcmEnable, .busEnable,
  .pcmLoop, .busLoop, .rateRange, .auxClockEnable, .softReset
);
`default_nettype wire

/* switch_config_command_and_irq_regs_tb.sv */
// self-checking bench for the config command block
`timescale 1ns/1ps
`default_nettype none
`include "switch_config_params.svh"
module switch_config_command_and_irq_regs_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic commandReady = 1'b1;
  logic connectionsFull = 1'b0;
  logic timeslotArrived = 1'b0;
  logic analogPllLock = 1'b0;
  logic wideInterface = 1'b0;
  logic [5:0] clockFailA = 6'h00;
  logic [7:0] clockFailB = 8'h00;
  logic [7:0] portInputs = 8'h00;
  logic [7:0] regRdData, auxClockEnable, auxClockFrame, auxClockInvert, shiftValue;
  logic [3:0] rateRange, shiftTarget;
  logic [1:0] streamMode;
  logic interruptRequestOut, interruptRequestOe, extFreqHalf, fallbackEnable, pllImproved;
  logic parallelMode, pcmEnable, busEnable, pcmClockSlave, pcmLoop, busLoop, streamActive;
  logic softReset;
  // model of the configuration levels
  logic ef, fb, par, pe, be, ps, pl, bl;
  logic [3:0] rr = 4'h1;
  logic [7:0] ae, af, ai, v, w;
  logic [3:0] c, i;
  logic [3:0] codes[8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hE};
  logic [4:0] rwAddr[4] = '{`OFS_MSG, `OFS_IMASK, `OFS_EMASK_A, `OFS_EMASK_B};
  logic [7:0] rwInit[4] = '{8'h00, `RST_IMASK, `RST_EMASK_A, `RST_EMASK_B};
  // mask registers keep their unused bits at zero
  logic [7:0] rwMask[4] = '{8'hFF, 8'h3D, 8'h3F, 8'hFF};
  integer seed = 32'h86054E53;
  int fails = 0;
  int checks = 0;
  switch_config_command_and_irq_regs switch_config_command_and_irq_regs_i (
    .core_clk, .sys_rst, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
    .commandReady, .connectionsFull, .timeslotArrived, .analogPllLock, .clockFailA,
    .clockFailB, .portInputs, .wideInterface, .interruptRequestOut, .interruptRequestOe,
    .extFreqHalf, .fallbackEnable, .pllImproved, .parallelMode, .pcmEnable, .busEnable,
    .pcmClockSlave, .pcmLoop, .busLoop, .rateRange, .auxClockEnable, .auxClockFrame,
    .auxClockInvert, .streamActive, .streamMode, .shiftTarget, .shiftValue, .softReset
  );
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // bus cycles: strobes last one clock, read data stands in the following cycle only
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {regAddr, regWrData, regWrStrobe} <= {a, d, 1'b1};
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    @(posedge core_clk);
    {regAddr, regRdStrobe} <= {a, 1'b1};
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    @(negedge core_clk);
    chk(regRdData, e);
  endtask
  // command write plus model update, then every level compared
  task automatic cmd(input logic [3:0] cc, input logic [3:0] ii);
    wr(`OFS_CMD_TWO, {ii, cc});
    case (cc)
      4'h1: {fb, ef} = ii[1:0];
      4'h2: par = ii[0];
      4'h4: {ps, be, pe} = {ii[3], ii[1:0]};
      4'h5: {bl, pl} = ii[1:0];
      4'h6: {ae[ii[2:0]], af[ii[2:0]], ai[ii[2:0]]} = {2'b11, ii[3]};
      4'h7: {ae[ii[2:0]], af[ii[2:0]]} = 2'b10;
      4'h8: rr = ii;
      default: ;
    endcase
    @(negedge core_clk);
    chk({extFreqHalf, fallbackEnable, parallelMode, pcmEnable, busEnable, pcmClockSlave,
      pcmLoop, busLoop}, {ef, fb, par, pe, be, ps, pl, bl});
    chk(auxClockEnable, ae);
    chk(auxClockInvert & af, ai & af);
    chk(auxClockFrame, af);
    chk({4'h0, rateRange}, {4'h0, rr});
  endtask
  task automatic end_of_test();
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // the whole sequence needs under two thousand clocks
  initial
  begin
    #2000000;
    fails++;
    end_of_test();
  end
  initial
  begin
    {ef, fb, par, pe, be, ps, pl, bl, ae, af, ai} = '0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    cmd(4'h1, 4'h5);
    chk({7'h00, pllImproved}, 8'h01);
    cmd(4'h8, 4'h5);
    rdc(`OFS_ISTA, 8'h01);
    rdc(5'h1D, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      rdc(rwAddr[k], rwInit[k]);
      v = $random(seed);
      wr(rwAddr[k], v);
      rdc(rwAddr[k], v & rwMask[k]);
      wr(rwAddr[k], rwInit[k]);
    end
    @(posedge core_clk) {analogPllLock, connectionsFull} <= 2'b11;
    rdc(`OFS_ISTA, 8'h83);
    @(posedge core_clk) {analogPllLock, connectionsFull} <= 2'b00;
    // stream switch and bit shift through the first command register
    wr(`OFS_SPA, 8'h03);
    wr(`OFS_DPA, 8'h05);
    wr(`OFS_CMD_ONE, 8'h6E);
    @(negedge core_clk) chk({5'h00, streamActive, streamMode}, 8'h06);
    rdc(`OFS_ISTA, 8'h41);
    // shift value kept in w for the later read-back of the shift settings
    w = $random(seed);
    wr(`OFS_GIN_ONE, w);
    wr(`OFS_CMD_ONE, 8'h3F);
    @(negedge core_clk) chk(shiftValue, w);
    chk({4'h0, shiftTarget}, 8'h08);
    wr(`OFS_CMD_ONE, 8'h8E);
    @(negedge core_clk) chk({7'h00, streamActive}, 8'h00);
    // random configuration commands, the reserved code among them
    for (int n = 0; n < 32; n++)
    begin
      c = codes[n % 8];
      v = $random(seed);
      i = v[3:0] & ((c == 4'h1 || c == 4'h4) ? 4'hB : 4'hF);
      cmd(c, i);
      rdc(`OFS_CMD_TWO, {i, c});
    end
    // read commands land in the value register and flag its arrival
    for (int n = 9; n < 14; n++)
    begin
      cmd(n[3:0], 4'hF);
      rdc(`OFS_ISTA, 8'h05);
      if (n == 9)
        rdc(`OFS_TSV, {4'h0, rr});
      else
        rdc(`OFS_TSV, n == 10 ? {7'h00, af[7]} : (n == 13 ? w : {4'h0, rr}));
      rdc(`OFS_ISTA, 8'h01);
    end
    // an arrival from the connection side sets the flag until the value is read
    @(posedge core_clk) timeslotArrived <= 1'b1;
    @(posedge core_clk) timeslotArrived <= 1'b0;
    rdc(`OFS_ISTA, 8'h05);
    rdc(`OFS_TSV, w);
    rdc(`OFS_ISTA, 8'h01);
    v = $random(seed) | 8'h01;
    @(posedge core_clk) portInputs <= v;
    rdc(`OFS_GPIN, v);
    rdc(`OFS_ISTA, 8'h09);
    rdc(`OFS_ISTA, 8'h01);
    // clock failures with fallback on, then recovery and re-arm
    cmd(4'h1, 4'h2);
    v = $random(seed) | 8'h01;
    w = $random(seed) & 8'hBF;
    @(posedge core_clk) {clockFailA, clockFailB} <= {v[5:0], w};
    rdc(`OFS_ESTA_A, {2'b00, v[5:0]});
    rdc(`OFS_ESTA_B, w | 8'h40);
    rdc(`OFS_ISTA, 8'h31);
    @(posedge core_clk) {clockFailA, clockFailB} <= 14'h0000;
    rdc(`OFS_ESTA_A, 8'h00);
    rdc(`OFS_ESTA_B, 8'h00);
    cmd(4'h1, 4'h0);
    cmd(4'h1, 4'h2);
    rdc(`OFS_ISTA, 8'h31);
    @(posedge core_clk) {wideInterface, clockFailB} <= {1'b1, 8'h01};
    rdc(`OFS_ESTA_B, 8'h41);
    rdc(`OFS_ISTA, 8'h01);
    // each pin style, with the ready flag unmasked and then masked
    for (int n = 0; n < 6; n++)
    begin
      cmd(4'h3, {1'b0, n[1], n[2:1]});
      wr(`OFS_IMASK, {7'h1E, n[0]});
      repeat (8) @(negedge core_clk);
      chk({7'h00, n[2] ? interruptRequestOe : interruptRequestOut},
        {7'h00, n[2:1] == 2'b00 ? n[0] : !n[0]});
    end
    wr(`OFS_CMD_TWO, 8'h1F);
    @(negedge core_clk) chk({7'h00, softReset}, 8'h01);
    wr(`OFS_CMD_TWO, 8'h0F);
    @(negedge core_clk) chk({7'h00, softReset}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
